// ==== rtl/uhirq_pkg.sv ====
// constants for the usb host interrupt status block
package uhirq_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_DISABLE = 8'h08;
  localparam logic [7:0] OFS_TALLY = 8'h0C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int NUM_FLAGS = 7;
  localparam int BIT_ROOT_PORT = 6;
  localparam int BIT_FRAME_WRAP = 5;
  localparam int BIT_FATAL = 4;
  localparam int BIT_RESUME = 3;
  localparam int BIT_FRAME_START = 2;
  localparam int BIT_DONE_LIST = 1;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_OWNERSHIP = 30;
  localparam int BIT_GLOBAL_GATE = 31;
  localparam int TALLY_LSB = 16;
  localparam int TALLY_W = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [6:0] RST_FLAGS = 7'h00;
  localparam logic [6:0] RST_ENABLE = 7'h00;
  localparam logic RST_GATE = 1'b0;
  localparam logic [1:0] RST_TALLY = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h00000000;
endpackage

// ==== rtl/uhirq_flags.sv ====
// sticky event flags with write-one-to-clear and overrun tally
`timescale 1ns/1ps
module uhirq_flags #(
  parameter int NFLAG = 7,
  parameter int TW = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // event and clear vectors
  input wire logic [NFLAG-1:0] set_vec,
  input wire logic [NFLAG-1:0] clr_vec,
  input wire logic tally_inc,
  // state out
  output logic [NFLAG-1:0] flags,
  output logic [TW-1:0] tally
);
  // all state of this module
  typedef struct packed {
    logic [NFLAG-1:0] flags;
    logic [TW-1:0] tally;
  } uhirq_flag_state_s;

  uhirq_flag_state_s st_ff;
  uhirq_flag_state_s nxt_st;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // set wins over a clear in the same cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_st.flags = (st_ff.flags & ~clr_vec) | set_vec;
    if (tally_inc) begin
      // counts even while the flag is pending
      nxt_st.tally = st_ff.tally + TW'(1);
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_ff.flags <= NFLAG'(uhirq_pkg::RST_FLAGS);
      st_ff.tally <= TW'(uhirq_pkg::RST_TALLY);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign flags = st_ff.flags;
  assign tally = st_ff.tally;
endmodule

// ==== rtl/uhirq_status.sv ====
// interrupt status, enable and gate logic of the usb host controller
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module uhirq_status #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // event pulses from the controller core
  input wire logic root_port_change_evt,
  input wire logic frame_count_wrap_evt,
  input wire logic system_bus_err_evt,
  input wire logic iso_cc_err_evt,
  input wire logic resume_evt,
  input wire logic frame_start_evt,
  input wire logic done_queue_head_upd_evt,
  input wire logic overrun_evt,
  // interrupt line to level 2 controller
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  // all registered state of this module
  typedef struct packed {
    logic [6:0] enable; // per-flag enables
    logic gate; // global irq gate
    logic [31:0] rdata; // read data register
  } uhirq_state_s;

  uhirq_state_s st_ff;
  uhirq_state_s nxt_st;

  // flag bank outputs
  logic [6:0] flags;
  logic [1:0] tally;

  // event and clear vectors
  logic [6:0] set_vec;
  logic [6:0] clr_vec;

  // address decodes
  logic hit_status;
  logic hit_enable;
  logic hit_disable;
  logic hit_tally;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // match an address against a register offset
  function automatic logic addr_is(input logic [AW-1:0] a, input logic [7:0] ofs);
    addr_is = (a == AW'(ofs));
  endfunction

  // enable register image as software sees it
  function automatic logic [31:0] enable_image(input logic g, input logic [6:0] en);
    logic [31:0] img;
    img = 32'h00000000;
    img[uhirq_pkg::BIT_GLOBAL_GATE] = g;
    img[6:0] = en;
    enable_image = img;
  endfunction

  assign hit_status = addr_is(reg_addr, uhirq_pkg::OFS_STATUS);
  assign hit_enable = addr_is(reg_addr, uhirq_pkg::OFS_ENABLE);
  assign hit_disable = addr_is(reg_addr, uhirq_pkg::OFS_DISABLE);
  assign hit_tally = addr_is(reg_addr, uhirq_pkg::OFS_TALLY);

  // ----------------------------------------
  // event gathering
  // ----------------------------------------
  // one set pulse per flag position
  always_comb begin
    set_vec = 7'h00;
    set_vec[uhirq_pkg::BIT_ROOT_PORT] = root_port_change_evt;
    set_vec[uhirq_pkg::BIT_FRAME_WRAP] = frame_count_wrap_evt;
    // either fatal source raises the same flag
    set_vec[uhirq_pkg::BIT_FATAL] = system_bus_err_evt | iso_cc_err_evt;
    set_vec[uhirq_pkg::BIT_RESUME] = resume_evt;
    set_vec[uhirq_pkg::BIT_FRAME_START] = frame_start_evt;
    set_vec[uhirq_pkg::BIT_DONE_LIST] = done_queue_head_upd_evt;
    set_vec[uhirq_pkg::BIT_OVERRUN] = overrun_evt;
  end

  // write one to a flag position clears it
  always_comb begin
    clr_vec = 7'h00;
    if (reg_wr && hit_status) begin
      // only the low seven bits are flags; the rest are dropped
      clr_vec = reg_wdata[6:0];
    end
  end

  // ----------------------------------------
  // flag bank
  // ----------------------------------------
  uhirq_flags #(
    .NFLAG(uhirq_pkg::NUM_FLAGS),
    .TW(uhirq_pkg::TALLY_W)
  ) u_flags (
    .clock(clock),
    .nrst(nrst),
    .set_vec(set_vec),
    .clr_vec(clr_vec),
    .tally_inc(overrun_evt),
    .flags(flags),
    .tally(tally)
  );

  // ----------------------------------------
  // register next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // read data stands for one cycle only
    nxt_st.rdata = 32'h00000000;
    // enable register: write one sets
    if (reg_wr && hit_enable) begin
      nxt_st.enable = st_ff.enable | reg_wdata[6:0];
      if (reg_wdata[uhirq_pkg::BIT_GLOBAL_GATE]) begin
        nxt_st.gate = 1'b1;
      end
    end
    // disable register: write one clears the enable
    if (reg_wr && hit_disable) begin
      nxt_st.enable = st_ff.enable & ~reg_wdata[6:0];
      if (reg_wdata[uhirq_pkg::BIT_GLOBAL_GATE]) begin
        nxt_st.gate = 1'b0;
      end
    end
    // read mux
    if (reg_rd) begin
      if (hit_status) begin
        // ownership and reserved bits stay zero
        nxt_st.rdata[6:0] = flags;
      end else if (hit_enable || hit_disable) begin
        // both addresses show the current enables
        nxt_st.rdata = enable_image(st_ff.gate, st_ff.enable);
      end else if (hit_tally) begin
        // overrun tally in its field
        nxt_st.rdata[uhirq_pkg::TALLY_LSB +: uhirq_pkg::TALLY_W] = tally;
      end else begin
        // unmapped address reads zero
        nxt_st.rdata = 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_ff.enable <= uhirq_pkg::RST_ENABLE;
      st_ff.gate <= uhirq_pkg::RST_GATE;
      st_ff.rdata <= uhirq_pkg::RST_RDATA;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // read data straight from the register
  assign reg_rdata = st_ff.rdata;

  // level interrupt from registered state
  assign irq = st_ff.gate && |(flags & st_ff.enable);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // root port event shows at bit 6 next cycle
  root_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    root_port_change_evt |=> flags[6]
  ) else $error("root port flag not set");

  // frame wrap flag holds until a write of one
  wrap_flag_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    flags[5] && !(reg_wr && hit_status && reg_wdata[5]) |=> flags[5]
  ) else $error("frame wrap flag dropped");

  // iso condition code error raises fatal flag
  fatal_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (system_bus_err_evt || iso_cc_err_evt) |=> flags[4]
  ) else $error("fatal flag not set");

  // resume request raises bit 3
  resume_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    resume_evt |=> flags[3]
  ) else $error("resume flag not set");

  // start of frame wins over a clear
  sof_set_wins_a: assert property (
    @(posedge clock) disable iff (!nrst)
    frame_start_evt && reg_wr && hit_status && reg_wdata[2] |=> flags[2]
  ) else $error("frame start flag lost to clear");

  // done head update raises bit 1, readable next
  done_flag_read_a: assert property (
    @(posedge clock) disable iff (!nrst)
    done_queue_head_upd_evt ##1 (reg_rd && hit_status) |=> reg_rdata[1]
  ) else $error("done list flag not visible");

  // overrun raises bit 0
  overrun_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    overrun_evt |=> flags[0]
  ) else $error("overrun flag not set");

  // write one clears, write zero keeps
  w1c_clear_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_wr && hit_status && set_vec == 7'h00)
      |=> flags == ($past(flags) & ~$past(reg_wdata[6:0]))
  ) else $error("write one to clear mismatch");

  // flags zero after reset release
  reset_flags_a: assert property (
    @(posedge clock)
    !nrst |=> flags == 7'h00
  ) else $error("flags not zero after reset");

  // reserved and ownership bits read zero
  reserved_zero_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_rd && hit_status |=> reg_rdata[31:7] == 25'h0000000
  ) else $error("reserved status bits not zero");

  // irq only with flag, enable and gate together
  irq_gate_a: assert property (
    @(posedge clock) disable iff (!nrst)
    irq |-> st_ff.gate && (flags & st_ff.enable) != 7'h00
  ) else $error("irq without gated enabled flag");

  // enabled flag with gate drives the line
  irq_raise_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (reg_wr && hit_enable && reg_wdata[31] && reg_wdata[0] && overrun_evt)
      |=> irq
  ) else $error("irq not raised");

  // tally advances on every overrun, even when pending
  tally_step_a: assert property (
    @(posedge clock) disable iff (!nrst)
    overrun_evt |=> tally == 2'($past(tally) + 2'h1)
  ) else $error("overrun tally did not advance");

  // tally stands still without an overrun
  tally_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    !overrun_evt |=> tally == $past(tally)
  ) else $error("overrun tally moved without overrun");

  // tally register shows the count in its field only
  tally_read_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_rd && hit_tally |=> reg_rdata == {14'h0000, $past(tally), 16'h0000}
  ) else $error("tally read image wrong");

  // read data return to zero when no read was made
  rdata_idle_zero_a: assert property (
    @(posedge clock) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 32'h00000000
  ) else $error("read data not zero outside a read");

  // status read shows the flags of the read cycle
  status_read_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_rd && hit_status |=> reg_rdata[6:0] == $past(flags)
  ) else $error("status read does not match flags");

  // a write of zeros to the flag field keeps every flag
  write_zero_keep_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_wr && hit_status && reg_wdata[6:0] == 7'h00
      |=> flags == ($past(flags) | $past(set_vec))
  ) else $error("flag changed on write of zero");

  // a flag only rises on its own event
  flag_rise_cause_a: assert property (
    @(posedge clock) disable iff (!nrst)
    nrst |=> (flags & ~$past(flags) & ~$past(set_vec)) == 7'h00
  ) else $error("flag rose without its event");

  // root port flag holds until a write of one
  root_flag_hold_a: assert property (
    @(posedge clock) disable iff (!nrst)
    flags[6] && !(reg_wr && hit_status && reg_wdata[6]) |=> flags[6]
  ) else $error("root port flag dropped");

  // start of frame raises bit 2
  sof_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    frame_start_evt |=> flags[2]
  ) else $error("frame start flag not set");

  // done head update raises bit 1
  done_flag_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    done_queue_head_upd_evt |=> flags[1]
  ) else $error("done list flag not set");

  // enable write of one sets the matching enables
  enable_set_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_wr && hit_enable
      |=> (st_ff.enable & $past(reg_wdata[6:0])) == $past(reg_wdata[6:0])
  ) else $error("enable bits not set by write");

  // disable write of one clears the matching enables
  enable_clear_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_wr && hit_disable |=> (st_ff.enable & $past(reg_wdata[6:0])) == 7'h00
  ) else $error("enable bits not cleared by write");

  // clearing the global gate silences the line
  gate_off_quiet_a: assert property (
    @(posedge clock) disable iff (!nrst)
    reg_wr && hit_disable && reg_wdata[31] |=> !irq
  ) else $error("irq high with gate cleared");

  // enabled overrun with the gate open raises the line
  irq_follow_a: assert property (
    @(posedge clock) disable iff (!nrst)
    overrun_evt && st_ff.gate && st_ff.enable[0] && !(reg_wr && hit_disable) |=> irq
  ) else $error("irq not raised by enabled overrun");
endmodule

// ==== sim/uhirq_evt_model.sv ====
// controller core model that issues event pulses on request
`timescale 1ns/1ps
module uhirq_evt_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // request from bench, one bit per source
  input wire logic [7:0] fire,
  // event pulses toward the status block
  output logic [7:0] evt
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] evt; // registered pulses
  } uhirq_model_s;
  uhirq_model_s state_ff; // current state
  uhirq_model_s nxt_state; // next state
  // one pulse per requested cycle, so a held request gives back-to-back events
  always_comb begin
    nxt_state = state_ff;
    nxt_state.evt = fire;
  end
  // register with synchronous reset
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign evt = state_ff.evt;
endmodule

// ==== sim/tb_uhirq_status.sv ====
// self-checking bench for the usb host interrupt status block
`timescale 1ns/1ps
module tb_uhirq_status;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] fire = 8'h00; // event requests to the model
  logic [7:0] evt; // model pulses
  logic irq;
  logic [31:0] rd; // last read word
  int n_fail = 0;
  int check_count = 0;
  int fbit [0:7] = '{6, 5, 4, 4, 3, 2, 1, 0}; // flag bit per source
  // ----------------------------------------
  // clock, model and design
  // ----------------------------------------
  initial begin
    forever #5 clock = ~clock;
  end
  uhirq_evt_model model (.clock(clock), .nrst(nrst), .fire(fire), .evt(evt));
  uhirq_status #(.AW(8)) dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .root_port_change_evt(evt[7]), .frame_count_wrap_evt(evt[6]),
    .system_bus_err_evt(evt[5]), .iso_cc_err_evt(evt[4]), .resume_evt(evt[3]),
    .frame_start_evt(evt[2]), .done_queue_head_upd_evt(evt[1]),
    .overrun_evt(evt[0]), .irq(irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare one word
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare the interrupt line after the last update has landed
  task automatic chk_irq(input logic exp);
    #1;
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  // single-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // single-cycle read, data taken in the following cycle
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
    chk(what, exp, rd);
  endtask
  // request events from the model for a number of cycles
  task automatic pulse(input logic [7:0] m, input int n);
    @(posedge clock);
    fire <= m;
    repeat (n) @(posedge clock);
    fire <= 8'h00;
    @(posedge clock);
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd_chk("status reset", 8'h00, 32'h00000000);
    rd_chk("enable reset", 8'h04, 32'h00000000);
    rd_chk("tally reset", 8'h0C, 32'h00000000);
    chk_irq(1'b0);
    // each source sets its own flag, write zero keeps it, write one clears it
    for (int i = 0; i < 8; i++) begin
      pulse(8'h80 >> i, 1);
      rd_chk("flag set", 8'h00, 32'h1 << fbit[i]);
      wr(8'h00, ~(32'h1 << fbit[i]) & 32'h0000007F);
      rd_chk("flag kept", 8'h00, 32'h1 << fbit[i]);
      wr(8'h00, 32'h1 << fbit[i]);
      rd_chk("flag cleared", 8'h00, 32'h00000000);
    end
    // done flag readable in the cycle right after its event
    @(posedge clock);
    fire <= 8'h02;
    @(posedge clock);
    fire <= 8'h00;
    rd_chk("done visible", 8'h00, 32'h00000002);
    wr(8'h00, 32'h00000002);
    // reserved and ownership bits stay zero
    pulse(8'h7F, 1);
    wr(8'h00, 32'hFFFFFF80);
    rd_chk("reserved zero", 8'h00, 32'h0000003F);
    rd_chk("unmapped", 8'h10, 32'h00000000);
    wr(8'h00, 32'hFFFFFFFF);
    // interrupt needs flag, enable and gate
    pulse(8'h01, 1);
    wr(8'h04, 32'h00000001);
    chk_irq(1'b0);
    wr(8'h04, 32'h80000000);
    chk_irq(1'b1);
    rd_chk("enable image", 8'h08, 32'h80000001);
    wr(8'h08, 32'h00000001);
    chk_irq(1'b0);
    wr(8'h04, 32'h00000040);
    chk_irq(1'b0);
    wr(8'h04, 32'h00000001);
    chk_irq(1'b1);
    wr(8'h00, 32'h00000001);
    chk_irq(1'b0);
    pulse(8'h01, 1);
    chk_irq(1'b1);
    wr(8'h08, 32'h80000000);
    pulse(8'h01, 1);
    chk_irq(1'b0);
    wr(8'h00, 32'h00000001);
    // tally counts every overrun, pending or not, and wraps
    rd_chk("tally before", 8'h0C, 32'h00010000);
    pulse(8'h01, 5);
    rd_chk("tally wrap", 8'h0C, 32'h00020000);
    wr(8'h0C, 32'h00000000);
    rd_chk("tally read only", 8'h0C, 32'h00020000);
    rd_chk("overrun pending", 8'h00, 32'h00000001);
    // reset in mid-run clears flags, enables and tally, with the gate already off
    rd_chk("enable before reset", 8'h04, 32'h00000041);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rd_chk("status after reset", 8'h00, 32'h00000000);
    rd_chk("enable after reset", 8'h04, 32'h00000000);
    rd_chk("tally after reset", 8'h0C, 32'h00000000);
    chk_irq(1'b0);
    wrap_up();
  end
endmodule
